// File: rtl/spc_pkg.sv
package spc_pkg;

  // Port geometry
  localparam int unsigned SPC_PINS = 6;
  localparam int unsigned SPC_ANS_W = 8;
  localparam int unsigned SPC_IN_PIN = 3;
  localparam int unsigned SPC_AN_OF_PIN4 = 3;

  // Register byte addresses
  localparam logic [7:0] SPC_OFS_PORT = 8'h00;
  localparam logic [7:0] SPC_OFS_DIR = 8'h04;
  localparam logic [7:0] SPC_OFS_ANALOG_SELECT = 8'h08;
  localparam logic [7:0] SPC_OFS_PULLUP = 8'h0c;
  localparam logic [7:0] SPC_OFS_CHG_EN = 8'h10;
  localparam logic [7:0] SPC_OFS_OPTION = 8'h14;
  localparam logic [7:0] SPC_OFS_INTCTL = 8'h18;
  localparam logic [7:0] SPC_OFS_CONFIG = 8'h1c;
  localparam logic [7:0] SPC_OFS_PORT_SET = 8'h20;
  localparam logic [7:0] SPC_OFS_PORT_CLR = 8'h24;

  // Field positions
  localparam int unsigned SPC_OPT_PU_DIS_BIT = 7;
  localparam int unsigned SPC_INT_FLAG_BIT = 0;
  localparam int unsigned SPC_CFG_XRST_BIT = 0;
  localparam int unsigned SPC_CFG_OSC_LSB = 1;

  // Values after reset, and the pull-up and oscillator pin masks
  localparam logic [5:0] SPC_RST_LATCH = 6'h00;
  localparam logic [5:0] SPC_WARM_KEEP_LATCH = 6'h28;
  localparam logic [5:0] SPC_RST_DIR = 6'h3f;
  localparam logic [7:0] SPC_RST_ANALOG_SELECT = 8'hff;
  localparam logic [5:0] SPC_RST_PULLUP = 6'h37;
  localparam logic [5:0] SPC_PULLUP_IMPL = 6'h37;
  localparam logic [5:0] SPC_RST_CHG_EN = 6'h00;
  localparam logic SPC_RST_PU_DIS = 1'b1;
  localparam logic [5:0] SPC_OSC_PINS = 6'h30;

  // Oscillator mode field
  typedef enum logic [1:0] {
    SPC_OSC_OTHER = 2'b00,
    SPC_OSC_LOW_POWER = 2'b01,
    SPC_OSC_MEDIUM = 2'b10,
    SPC_OSC_HIGH = 2'b11
  } spc_osc_e;

  // Bus data phase kinds
  typedef enum logic [1:0] {
    SPC_BUS_IDLE = 2'b00,
    SPC_BUS_WRITE = 2'b01,
    SPC_BUS_READ = 2'b10
  } spc_bus_e;

  // Pad drive toward the pin cells
  typedef struct packed {
    logic [5:0] pullup_on;
    logic [5:0] oe;
    logic [5:0] out;
  } spc_pad_s;

endpackage

// File: rtl/spc_sync.sv
`timescale 1ns/1ps
module spc_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Two flops per bit; only the second stage is seen outside
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// File: rtl/spc_port.sv
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module spc_port
  import spc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic warm_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] pin_in,
  output spc_pad_s pad,
  output logic change_irq_flag,
  output logic wake_req
);

  logic [5:0] pin_sync;
  logic [5:0] pin_level;
  logic [5:0] ana_pin;
  logic [5:0] port_latch;
  logic [5:0] port_direction;
  logic [7:0] analog_select;
  logic [5:0] pullup_enable_bit;
  logic [5:0] change_irq_enable_bit;
  logic global_pullup_disable_n;
  logic ext_reset_pin_enable;
  spc_osc_e osc_mode;
  logic crystal;
  logic [5:0] dir_view;
  logic [5:0] chg_en_view;
  logic [5:0] snapshot;
  logic mismatch;
  spc_bus_e bus_phase;
  logic [7:0] addr_q;
  logic take;
  logic wr_now;
  logic rd_now;
  logic port_access;
  logic [31:0] rd_value;
  logic [5:0] wdata6;
  logic [5:0] next_latch;

  // Pins come from the board, so they cross into hclk first
  spc_sync #(
    .WIDTH(SPC_PINS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Analog channels per pin; pins 3 and 5 carry no channel
  assign ana_pin = {1'b0, analog_select[SPC_AN_OF_PIN4], 1'b0, analog_select[2:0]};

  // Digital view of the pins as software sees it
  always_comb
  begin
    pin_level = pin_sync & ~ana_pin;
    if (ext_reset_pin_enable)
    begin
      pin_level[SPC_IN_PIN] = 1'b0;
    end
  end

  // Oscillator pins report as inputs in crystal modes
  assign crystal = (osc_mode != SPC_OSC_OTHER);
  assign dir_view = port_direction | (crystal ? SPC_OSC_PINS : 6'h00);
  assign chg_en_view = change_irq_enable_bit | (crystal ? SPC_OSC_PINS : 6'h00);

  // Address phase; only word transfers are expected
  assign take = hsel && hready && htrans[1];
  assign wr_now = (bus_phase == SPC_BUS_WRITE);
  assign rd_now = (bus_phase == SPC_BUS_READ);
  assign wdata6 = hwdata[5:0];

  // One wait state on reads lets a preceding write settle first
  assign hreadyout = !rd_now;
  assign hresp = 1'b0;

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_phase <= SPC_BUS_IDLE;
      addr_q <= 8'h00;
    end
    else if (rd_now)
    begin
      bus_phase <= SPC_BUS_IDLE;
    end
    else if (take)
    begin
      bus_phase <= hwrite ? SPC_BUS_WRITE : SPC_BUS_READ;
      addr_q <= haddr[7:0];
    end
    else
    begin
      bus_phase <= SPC_BUS_IDLE;
    end
  end

  // Any read or write of the port touches the snapshot
  assign port_access = (rd_now && addr_q == SPC_OFS_PORT)
    || (wr_now && (addr_q == SPC_OFS_PORT || addr_q == SPC_OFS_PORT_SET || addr_q == SPC_OFS_PORT_CLR));

  // Latch update: port writes store the data; set and clear read the pins, modify and store
  always_comb
  begin
    next_latch = port_latch;
    if (wr_now)
    begin
      unique case (addr_q)
        SPC_OFS_PORT: next_latch = wdata6;
        SPC_OFS_PORT_SET: next_latch = pin_level | wdata6;
        SPC_OFS_PORT_CLR: next_latch = pin_level & ~wdata6;
        default: next_latch = port_latch;
      endcase
    end
  end

  // Output latch; some bits keep their value over warm resets
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_latch <= SPC_RST_LATCH;
    end
    else if (warm_reset)
    begin
      port_latch <= port_latch & SPC_WARM_KEEP_LATCH;
    end
    else
    begin
      port_latch <= next_latch;
    end
  end

  // Direction register; pin 3 is stored as input regardless
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_direction <= SPC_RST_DIR;
    end
    else if (warm_reset)
    begin
      port_direction <= SPC_RST_DIR;
    end
    else if (wr_now && addr_q == SPC_OFS_DIR)
    begin
      port_direction <= wdata6 | (6'h01 << SPC_IN_PIN);
    end
  end

  // Analog select register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      analog_select <= SPC_RST_ANALOG_SELECT;
    end
    else if (warm_reset)
    begin
      analog_select <= SPC_RST_ANALOG_SELECT;
    end
    else if (wr_now && addr_q == SPC_OFS_ANALOG_SELECT)
    begin
      analog_select <= hwdata[SPC_ANS_W-1:0];
    end
  end

  // Pull-up enables; pin 3 has no software bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pullup_enable_bit <= SPC_RST_PULLUP;
    end
    else if (warm_reset)
    begin
      pullup_enable_bit <= SPC_RST_PULLUP;
    end
    else if (wr_now && addr_q == SPC_OFS_PULLUP)
    begin
      pullup_enable_bit <= wdata6 & SPC_PULLUP_IMPL;
    end
  end

  // Change enables start cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      change_irq_enable_bit <= SPC_RST_CHG_EN;
    end
    else if (warm_reset)
    begin
      change_irq_enable_bit <= SPC_RST_CHG_EN;
    end
    else if (wr_now && addr_q == SPC_OFS_CHG_EN)
    begin
      change_irq_enable_bit <= wdata6;
    end
  end

  // Global pull-up disable, set at reset so pull-ups start off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      global_pullup_disable_n <= SPC_RST_PU_DIS;
    end
    else if (warm_reset)
    begin
      global_pullup_disable_n <= SPC_RST_PU_DIS;
    end
    else if (wr_now && addr_q == SPC_OFS_OPTION)
    begin
      global_pullup_disable_n <= hwdata[SPC_OPT_PU_DIS_BIT];
    end
  end

  // Configuration: reset-pin mode and oscillator mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_reset_pin_enable <= 1'b0;
      osc_mode <= SPC_OSC_OTHER;
    end
    else if (wr_now && addr_q == SPC_OFS_CONFIG)
    begin
      ext_reset_pin_enable <= hwdata[SPC_CFG_XRST_BIT];
      osc_mode <= spc_osc_e'(hwdata[SPC_CFG_OSC_LSB +: 2]);
    end
  end

  // Last-read snapshot; warm resets deliberately leave it alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      snapshot <= 6'h00;
    end
    else if (port_access)
    begin
      snapshot <= pin_level;
    end
  end

  // Enabled digital pins only; analog ones are masked out
  assign mismatch = |((pin_level ^ snapshot) & change_irq_enable_bit & ~ana_pin);

  // Change flag: a live mismatch beats a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      change_irq_flag <= 1'b0;
    end
    else if (warm_reset)
    begin
      change_irq_flag <= 1'b0;
    end
    else if (mismatch)
    begin
      change_irq_flag <= 1'b1;
    end
    else if (wr_now && addr_q == SPC_OFS_INTCTL && !hwdata[SPC_INT_FLAG_BIT])
    begin
      change_irq_flag <= 1'b0;
    end
  end

  // Wake request mirrors the flag so sleep logic can use it
  assign wake_req = change_irq_flag;

  // Pad drive, registered so the pins never see decode glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pad <= '0;
    end
    else
    begin
      pad.out <= port_latch;
      pad.oe <= ~dir_view;
      pad.pullup_on <= ~dir_view & 6'h00
        | (dir_view & pullup_enable_bit & ~ana_pin
        & {SPC_PINS{!global_pullup_disable_n}});
      pad.pullup_on[SPC_IN_PIN] <= ext_reset_pin_enable;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (addr_q)
      SPC_OFS_PORT: rd_value[5:0] = pin_level;
      SPC_OFS_DIR: rd_value[5:0] = dir_view | (6'h01 << SPC_IN_PIN);
      SPC_OFS_ANALOG_SELECT: rd_value[SPC_ANS_W-1:0] = analog_select;
      SPC_OFS_PULLUP: rd_value[5:0] = pullup_enable_bit | (crystal ? SPC_OSC_PINS : 6'h00);
      SPC_OFS_CHG_EN: rd_value[5:0] = chg_en_view;
      SPC_OFS_OPTION: rd_value[SPC_OPT_PU_DIS_BIT] = global_pullup_disable_n;
      SPC_OFS_INTCTL: rd_value[SPC_INT_FLAG_BIT] = change_irq_flag;
      SPC_OFS_CONFIG:
      begin
        rd_value[SPC_CFG_XRST_BIT] = ext_reset_pin_enable;
        rd_value[SPC_CFG_OSC_LSB +: 2] = osc_mode;
      end
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Read data register, loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_now)
    begin
      hrdata <= rd_value;
    end
  end

endmodule

// File: verification/spc_pins.sv
`timescale 1ns/1ps
module spc_pins
  import spc_pkg::*;
(
  input wire logic hclk,
  input wire spc_pad_s pad,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pin_in
);
  logic tog = 1'b0;
  // Floating pins toggle every clock, so a missing pull-up does not read as a steady 1
  always_ff @(posedge hclk)
    tog <= ~tog;
  // Pin level: our driver, else board driver, else pull-up, else float
  always_comb
    for (int i = 0; i < 6; i++)
      pin_in[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pad.pullup_on[i] ? 1'b1 : tog;
endmodule

// File: verification/spc_port_chk.sv
`timescale 1ns/1ps
module spc_port_chk
  import spc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic warm_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire spc_pad_s pad,
  input wire logic change_irq_flag,
  input wire logic wake_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req;
  logic dir_dp;
  logic ictl_dp;
  assign req = hsel && hready && htrans[1];
  // Data-phase markers for direction and interrupt-control writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dir_dp <= 1'b0;
      ictl_dp <= 1'b0;
    end
    else
    begin
      dir_dp <= req && hwrite && haddr[7:0] == SPC_OFS_DIR;
      ictl_dp <= req && hwrite && haddr[7:0] == SPC_OFS_INTCTL;
    end
  a_wake_flag: assert property (wake_req == change_irq_flag)
    else $error("wake request differs from change flag");
  a_pin3_input: assert property (!pad.oe[SPC_IN_PIN])
    else $error("pin 3 driven");
  a_pullup_output: assert property ((pad.oe & pad.pullup_on) == 6'h00)
    else $error("pull-up on a driven pin");
  a_reset_pullups: assert property ($rose(hresetn) |-> (pad.pullup_on == 6'h00) [*2])
    else $error("pull-up on after reset");
  a_reset_quiet: assert property ($rose(hresetn) |-> !change_irq_flag [*3])
    else $error("change flag after reset");
  a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_flag_sticky: assert property (change_irq_flag && !ictl_dp && !warm_reset |=> change_irq_flag)
    else $error("change flag dropped on its own");
  a_dir_drives: assert property (dir_dp && !warm_reset ##1 !dir_dp && !warm_reset
    |=> pad.oe[2:0] == ~$past(hwdata[2:0], 2))
    else $error("output enable does not follow direction");
endmodule
bind spc_port spc_port_chk u_chk (.hclk(hclk), .hresetn(hresetn), .warm_reset(warm_reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .pad(pad), .change_irq_flag(change_irq_flag), .wake_req(wake_req));

// File: verification/six_pin_port_with_change_detect_tb.sv
`timescale 1ns/1ps
module six_pin_port_with_change_detect_tb;
  import spc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic warm_reset = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic flag;
  logic wake;
  logic rd_ph = 1'b0;
  logic [5:0] pin_in;
  logic [5:0] ext_en = 6'h3f;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] m;
  logic [31:0] r;
  logic [31:0] d;
  logic [31:0] seed = 32'h15;
  logic [31:0] exq[$];
  spc_pad_s pad;
  int bad_count = 0;
  int num_checks = 0;
  spc_port dut (.hclk(hclk), .hresetn(hresetn), .warm_reset(warm_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pad(pad),
    .change_irq_flag(flag), .wake_req(wake));
  spc_pins u_pins (.hclk(hclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // 125 MHz clock
  initial
    forever #4 hclk = ~hclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait for hready; a stuck bus ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? v : 32'h0;
    wait_rdy;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // Read data is matched against the oldest note when the data phase ends
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
    begin
      chk("hrdata", exq.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
      rd_ph = 1'b0;
    end
    if (hsel && hreadyout && htrans[1] && !hwrite)
      rd_ph = 1'b1;
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(SPC_OFS_DIR, {26'h0, SPC_RST_DIR});
    rd(SPC_OFS_ANALOG_SELECT, {24'h0, SPC_RST_ANALOG_SELECT});
    rd(SPC_OFS_CHG_EN, {26'h0, SPC_RST_CHG_EN});
    rd(SPC_OFS_PULLUP, {26'h0, SPC_RST_PULLUP});
    rd(8'h30, 32'h0);
    chk("pullup_on", 32'h0, {26'h0, pad.pullup_on});
    // Analog pins read 0, the rest read their levels
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      ext_val <= r[5:0];
      wr(SPC_OFS_ANALOG_SELECT, {24'h0, r[15:8]});
      m = {1'b0, r[11], 1'b0, r[10:8]};
      rd(SPC_OFS_PORT, {26'h0, r[5:0] & ~m});
    end
    ext_val <= 6'h3f;
    wr(SPC_OFS_ANALOG_SELECT, 32'h0);
    wr(SPC_OFS_CONFIG, 32'h1);
    rd(SPC_OFS_PORT, 32'h37);
    chk("pullup3", 32'h1, {31'h0, pad.pullup_on[3]});
    wr(SPC_OFS_CONFIG, 32'h0);
    idle(2);
    chk("pullup3", 32'h0, {31'h0, pad.pullup_on[3]});
    for (int k = 1; k < 4; k++)
    begin
      wr(SPC_OFS_CONFIG, 32'(k * 2));
      wr(SPC_OFS_DIR, 32'h0);
      wr(SPC_OFS_CHG_EN, 32'h0);
      rd(SPC_OFS_DIR, 32'h38);
      rd(SPC_OFS_CHG_EN, 32'h30);
    end
    wr(SPC_OFS_CONFIG, 32'h0);
    // Drive with analog select set; bit set sees analog pins as 0
    d = xs();
    wr(SPC_OFS_ANALOG_SELECT, 32'hff);
    wr(SPC_OFS_DIR, 32'h08);
    wr(SPC_OFS_PORT, d);
    idle(2);
    chk("oe", 32'h37, {26'h0, pad.oe});
    chk("out", d & 32'h37, {26'h0, pad.out & 6'h37});
    wr(SPC_OFS_PORT_SET, 32'h04);
    idle(2);
    chk("out", (d & 32'h20) | 32'h04, {26'h0, pad.out & 6'h37});
    wr(SPC_OFS_ANALOG_SELECT, 32'h0);
    wr(SPC_OFS_PORT_SET, 32'h01);
    // Pins follow the latch one pad edge plus two sync edges later
    idle(3);
    rd(SPC_OFS_PORT, (d & 32'h20) | 32'h0d);
    wr(SPC_OFS_PORT_CLR, 32'h04);
    idle(2);
    chk("out", (d & 32'h20) | 32'h01, {26'h0, pad.out & 6'h37});
    // Pull-ups need global enable and an input pin
    ext_en <= 6'h08;
    wr(SPC_OFS_DIR, 32'h3f);
    wr(SPC_OFS_OPTION, 32'h0);
    idle(2);
    chk("pullup_on", 32'h37, {26'h0, pad.pullup_on});
    rd(SPC_OFS_PORT, 32'h3f);
    wr(SPC_OFS_DIR, 32'h0c);
    idle(2);
    chk("pullup_on", 32'h04, {26'h0, pad.pullup_on});
    wr(SPC_OFS_OPTION, 32'h80);
    idle(2);
    chk("pullup_on", 32'h0, {26'h0, pad.pullup_on});
    ext_en <= 6'h3f;
    wr(SPC_OFS_DIR, 32'h3f);
    wr(SPC_OFS_CHG_EN, 32'h3f);
    // Each pin in turn: set, hold against a clear, then clear after a read
    for (int k = 0; k < 6; k++)
    begin
      rd(SPC_OFS_PORT, {26'h0, ext_val});
      wr(SPC_OFS_INTCTL, 32'h0);
      idle(1);
      chk("flag", 32'h0, {31'h0, flag});
      ext_val <= ext_val ^ (6'h01 << k);
      idle(4);
      chk("flag", 32'h1, {31'h0, flag});
      chk("wake", 32'h1, {31'h0, wake});
      wr(SPC_OFS_INTCTL, 32'h0);
      idle(1);
      chk("flag", 32'h1, {31'h0, flag});
    end
    rd(SPC_OFS_PORT, {26'h0, ext_val});
    wr(SPC_OFS_INTCTL, 32'h0);
    wr(SPC_OFS_CHG_EN, 32'h3e);
    ext_val <= ext_val ^ 6'h01;
    idle(4);
    chk("flag", 32'h0, {31'h0, flag});
    // Snapshot holds a 1 on pin 0, so only the analog mask keeps the flag low
    rd(SPC_OFS_PORT, {26'h0, ext_val});
    wr(SPC_OFS_ANALOG_SELECT, 32'h01);
    wr(SPC_OFS_CHG_EN, 32'h3f);
    ext_val <= ext_val ^ 6'h01;
    idle(4);
    chk("flag", 32'h0, {31'h0, flag});
    // Snapshot must outlive a warm reset
    wr(SPC_OFS_ANALOG_SELECT, 32'h0);
    // Snapshot all ones, pins all zeros: a cleared snapshot would hide the change
    ext_val <= 6'h3f;
    idle(3);
    rd(SPC_OFS_PORT, {26'h0, ext_val});
    ext_val <= ~ext_val;
    warm_reset <= 1'b1;
    @(posedge hclk);
    warm_reset <= 1'b0;
    wr(SPC_OFS_ANALOG_SELECT, 32'h0);
    wr(SPC_OFS_CHG_EN, 32'h3f);
    idle(2);
    chk("flag", 32'h1, {31'h0, flag});
    close_out;
  end
endmodule
